// ### logic/prs_pkg.sv
// constants shared by the proximity result readout block
// assumes a single 100 MHz clock domain and an i2c slave port
package prs_pkg;

   // ==========================================================
   // register offsets (5-bit register address space)
   localparam logic [4:0] ADDR_ENABLE    = 5'h00;
   localparam logic [4:0] ADDR_THR_LO_L  = 5'h08;
   localparam logic [4:0] ADDR_THR_LO_H  = 5'h09;
   localparam logic [4:0] ADDR_THR_HI_L  = 5'h0a;
   localparam logic [4:0] ADDR_THR_HI_H  = 5'h0b;
   localparam logic [4:0] ADDR_PART_ID   = 5'h12;
   localparam logic [4:0] ADDR_STATUS    = 5'h13;
   localparam logic [4:0] ADDR_COUNT_LO  = 5'h18;
   localparam logic [4:0] ADDR_COUNT_HI  = 5'h19;

   // ==========================================================
   // field positions
   localparam int IRQ_MASK_BIT  = 5;
   localparam int IRQ_FLAG_BIT  = 5;
   localparam int CMD_SEL_BIT   = 7;
   localparam int CMD_TYPE_MSB  = 6;
   localparam int CMD_TYPE_LSB  = 5;

   // ==========================================================
   // command byte encodings
   localparam logic [1:0] TYPE_REPEAT  = 2'h0;
   localparam logic [1:0] TYPE_AUTOINC = 2'h1;
   localparam logic [1:0] TYPE_SPECIAL = 2'h3;
   localparam logic [4:0] SF_IRQ_CLEAR = 5'h05;

   // ==========================================================
   // reset values and fixed codes
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] THR_RESET    = 8'h00;
   localparam logic [7:0] BYTE_ZERO    = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ==========================================================
   // i2c slave states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_ACK_A = 3'b010,
      ST_RX    = 3'b011,
      ST_ACK_W = 3'b100,
      ST_TX    = 3'b101,
      ST_MACK  = 3'b110
   } prs_state_t;

endpackage

// ### logic/prs_result_hold.sv
// proximity result holder with the upper-byte shadow latch
// assumes result_valid pulses once per finished conversion
`timescale 1ns/1ps

module prs_result_hold (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // conversion side
   input  wire logic        result_valid,
   input  wire logic [15:0] result,
   // read side
   input  wire logic        low_read,
   output logic      [7:0]  count_low,
   output logic      [7:0]  count_high
);

   logic [15:0] result_q;
   logic [15:0] result_d;
   logic [7:0]  shadow_q;
   logic [7:0]  shadow_d;

   // ==========================================================
   // next state
   always_comb begin
      result_d = result_q;
      shadow_d = shadow_q;
      if (result_valid) begin
         result_d = result;
      end
      // the latch is taken from the held value, so a conversion ending
      // in this same cycle goes to the next pair of reads
      if (low_read) begin
         shadow_d = result_q[15:8];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         result_q <= 16'h0000;
         shadow_q <= 8'h00;
      end else begin
         result_q <= result_d;
         shadow_q <= shadow_d;
      end
   end

   assign count_low  = result_q[7:0];
   assign count_high = shadow_q;

endmodule

// ### logic/prs_readout.sv
// proximity result readout: i2c slave, register map, irq flag and pin
// assumes scl/sda inputs already synchronous to clk; open-drain pins
// are resolved outside from the enables
`timescale 1ns/1ps

module prs_readout #(
   parameter logic [6:0] SLAVE_ADDR = 7'h2a,
   // arbitrary identification value
   parameter logic [7:0] PART_CODE  = 8'h5a
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // i2c pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // interrupt pin
   output logic             irq_o,
   output logic             irq_oe,
   // conversion results
   input  wire logic        result_valid,
   input  wire logic [15:0] result
);

   prs_pkg::prs_state_t st_q, st_d;
   logic       scl_q, sda_q;
   logic [7:0] sh_q, sh_d;
   logic [3:0] cnt_q, cnt_d;
   logic [4:0] ptr_q, ptr_d;
   logic [1:0] type_q, type_d;
   logic       rw_q, rw_d;
   logic       first_q, first_d;
   logic       oe_q, oe_d;
   logic       mack_q, mack_d;
   logic [7:0] enable_q, enable_d;
   logic [7:0] thr_lo_l_q, thr_lo_l_d, thr_lo_h_q, thr_lo_h_d;
   logic [7:0] thr_hi_l_q, thr_hi_l_d, thr_hi_h_q, thr_hi_h_d;
   logic       flag_q, flag_d;
   logic       low_read;
   logic [7:0] rd_byte;
   logic [7:0] count_low, count_high, status;
   logic       scl_rise, scl_fall, start_c, stop_c;
   logic       irq_clear, irq_event;
   logic [15:0] thr_lo, thr_hi;
   logic [7:0] rx_byte;

   // ==========================================================
   // result storage
   prs_result_hold u_hold (
      .clk          (clk),
      .reset_n      (reset_n),
      .result_valid (result_valid),
      .result       (result),
      .low_read     (low_read),
      .count_low    (count_low),
      .count_high   (count_high)
   );

   // ==========================================================
   // read data mux
   always_comb begin
      status = prs_pkg::BYTE_ZERO;
      status[prs_pkg::IRQ_FLAG_BIT] = flag_q;
      if (ptr_q == prs_pkg::ADDR_ENABLE) begin
         rd_byte = enable_q;
      end else if (ptr_q == prs_pkg::ADDR_THR_LO_L) begin
         rd_byte = thr_lo_l_q;
      end else if (ptr_q == prs_pkg::ADDR_THR_LO_H) begin
         rd_byte = thr_lo_h_q;
      end else if (ptr_q == prs_pkg::ADDR_THR_HI_L) begin
         rd_byte = thr_hi_l_q;
      end else if (ptr_q == prs_pkg::ADDR_THR_HI_H) begin
         rd_byte = thr_hi_h_q;
      end else if (ptr_q == prs_pkg::ADDR_PART_ID) begin
         rd_byte = PART_CODE;
      end else if (ptr_q == prs_pkg::ADDR_STATUS) begin
         rd_byte = status;
      end else if (ptr_q == prs_pkg::ADDR_COUNT_LO) begin
         rd_byte = count_low;
      end else if (ptr_q == prs_pkg::ADDR_COUNT_HI) begin
         rd_byte = count_high;
      end else begin
         rd_byte = prs_pkg::BYTE_ZERO;
      end
   end

   // ==========================================================
   // bus events
   assign scl_rise = scl_i & ~scl_q;
   assign scl_fall = ~scl_i & scl_q;
   assign start_c  = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_c   = scl_i & scl_q & ~sda_q & sda_i;
   assign rx_byte  = sh_q;
   assign thr_lo   = {thr_lo_h_q, thr_lo_l_q};
   assign thr_hi   = {thr_hi_h_q, thr_hi_l_q};

   // ==========================================================
   // next state: protocol, registers, flag clear pulse
   always_comb begin
      st_d       = st_q;
      sh_d       = sh_q;
      cnt_d      = cnt_q;
      ptr_d      = ptr_q;
      type_d     = type_q;
      rw_d       = rw_q;
      first_d    = first_q;
      oe_d       = oe_q;
      mack_d     = mack_q;
      enable_d   = enable_q;
      thr_lo_l_d = thr_lo_l_q;
      thr_lo_h_d = thr_lo_h_q;
      thr_hi_l_d = thr_hi_l_q;
      thr_hi_h_d = thr_hi_h_q;
      low_read   = 1'b0;
      irq_clear  = 1'b0;
      if (start_c) begin
         st_d  = prs_pkg::ST_ADDR;
         cnt_d = 4'h0;
         oe_d  = 1'b0;
      end else if (stop_c) begin
         st_d = prs_pkg::ST_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            prs_pkg::ST_ADDR, prs_pkg::ST_RX: begin
               if (scl_rise) begin
                  sh_d  = {sh_q[6:0], sda_i};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall
                            && cnt_q == prs_pkg::BITS_PER_BYTE) begin
                  if (st_q == prs_pkg::ST_ADDR) begin
                     if (rx_byte[7:1] == SLAVE_ADDR) begin
                        rw_d    = rx_byte[0];
                        first_d = 1'b1;
                        oe_d    = 1'b1;
                        st_d    = prs_pkg::ST_ACK_A;
                     end else begin
                        st_d = prs_pkg::ST_IDLE;
                     end
                  end else begin
                     oe_d    = 1'b1;
                     first_d = 1'b0;
                     st_d    = prs_pkg::ST_ACK_W;
                     if (first_q && rx_byte[prs_pkg::CMD_SEL_BIT]) begin
                        type_d = rx_byte[prs_pkg::CMD_TYPE_MSB:
                                         prs_pkg::CMD_TYPE_LSB];
                        if (type_d == prs_pkg::TYPE_SPECIAL) begin
                           // one-cycle pulse, nothing to release later
                           irq_clear = (rx_byte[4:0]
                                        == prs_pkg::SF_IRQ_CLEAR);
                        end else begin
                           ptr_d = rx_byte[4:0];
                        end
                     end else begin
                        // identity, status and count writes fall through
                        if (ptr_q == prs_pkg::ADDR_ENABLE) begin
                           enable_d = rx_byte;
                        end else if (ptr_q == prs_pkg::ADDR_THR_LO_L) begin
                           thr_lo_l_d = rx_byte;
                        end else if (ptr_q == prs_pkg::ADDR_THR_LO_H) begin
                           thr_lo_h_d = rx_byte;
                        end else if (ptr_q == prs_pkg::ADDR_THR_HI_L) begin
                           thr_hi_l_d = rx_byte;
                        end else if (ptr_q == prs_pkg::ADDR_THR_HI_H) begin
                           thr_hi_h_d = rx_byte;
                        end
                        if (type_q == prs_pkg::TYPE_AUTOINC) begin
                           ptr_d = ptr_q + 5'h01;
                        end
                     end
                  end
               end
            end
            prs_pkg::ST_ACK_A, prs_pkg::ST_ACK_W: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (st_q == prs_pkg::ST_ACK_A && rw_q) begin
                     sh_d     = rd_byte;
                     oe_d     = ~rd_byte[7];
                     low_read = (ptr_q == prs_pkg::ADDR_COUNT_LO);
                     st_d     = prs_pkg::ST_TX;
                  end else begin
                     oe_d = 1'b0;
                     st_d = prs_pkg::ST_RX;
                  end
               end
            end
            prs_pkg::ST_TX: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == prs_pkg::BITS_PER_BYTE) begin
                     oe_d = 1'b0;
                     st_d = prs_pkg::ST_MACK;
                     if (type_q == prs_pkg::TYPE_AUTOINC) begin
                        ptr_d = ptr_q + 5'h01;
                     end
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = ~sh_q[6];
                  end
               end
            end
            prs_pkg::ST_MACK: begin
               if (scl_rise) begin
                  mack_d = ~sda_i;
               end else if (scl_fall) begin
                  if (mack_q) begin
                     cnt_d    = 4'h0;
                     sh_d     = rd_byte;
                     oe_d     = ~rd_byte[7];
                     low_read = (ptr_q == prs_pkg::ADDR_COUNT_LO);
                     st_d     = prs_pkg::ST_TX;
                  end else begin
                     st_d = prs_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               st_d = prs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // interrupt flag: a new event wins over a clear in the same cycle
   assign irq_event = result_valid
                      && enable_q[prs_pkg::IRQ_MASK_BIT]
                      && (result < thr_lo || result > thr_hi);

   always_comb begin
      flag_d = flag_q;
      if (irq_clear) begin
         flag_d = 1'b0;
      end
      if (irq_event) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q       <= prs_pkg::ST_IDLE;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
         sh_q       <= prs_pkg::BYTE_ZERO;
         cnt_q      <= 4'h0;
         ptr_q      <= 5'h00;
         type_q     <= prs_pkg::TYPE_REPEAT;
         rw_q       <= 1'b0;
         first_q    <= 1'b0;
         oe_q       <= 1'b0;
         mack_q     <= 1'b0;
         enable_q   <= prs_pkg::ENABLE_RESET;
         thr_lo_l_q <= prs_pkg::THR_RESET;
         thr_lo_h_q <= prs_pkg::THR_RESET;
         thr_hi_l_q <= prs_pkg::THR_RESET;
         thr_hi_h_q <= prs_pkg::THR_RESET;
         flag_q     <= 1'b0;
      end else begin
         st_q       <= st_d;
         scl_q      <= scl_i;
         sda_q      <= sda_i;
         sh_q       <= sh_d;
         cnt_q      <= cnt_d;
         ptr_q      <= ptr_d;
         type_q     <= type_d;
         rw_q       <= rw_d;
         first_q    <= first_d;
         oe_q       <= oe_d;
         mack_q     <= mack_d;
         enable_q   <= enable_d;
         thr_lo_l_q <= thr_lo_l_d;
         thr_lo_h_q <= thr_lo_h_d;
         thr_hi_l_q <= thr_hi_l_d;
         thr_hi_h_q <= thr_hi_h_d;
         flag_q     <= flag_d;
      end
   end

   // ==========================================================
   // pins: both are open drain, the driven level is always low
   assign sda_o  = 1'b0;
   assign sda_oe = oe_q;
   assign irq_o  = 1'b0;
   assign irq_oe = flag_q;

endmodule

// ### verification/prs_checker.sv
// port checker for the proximity result readout
// assumes open-drain pins resolved outside and scl/sda synchronous to clk
`timescale 1ns/1ps

module prs_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // i2c pins
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   // interrupt pin
   input wire logic        irq_o,
   input wire logic        irq_oe,
   // conversion results
   input wire logic        result_valid,
   input wire logic [15:0] result
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // ==========================================================
   // cycles since scl last moved; a clear needs recent bus traffic
   logic       scl_q;
   logic       scl_d;
   logic [4:0] idle_q;
   logic [4:0] idle_d;

   always_comb begin
      scl_d  = scl_i;
      idle_d = (scl_i != scl_q) ? 5'h00 :
               ((idle_q == 5'h1f) ? idle_q : idle_q + 5'h01);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q  <= 1'b1;
         idle_q <= 5'h00;
      end else begin
         scl_q  <= scl_d;
         idle_q <= idle_d;
      end
   end

   // ==========================================================
   // properties
   property p_irq_pin;
      irq_oe |-> !irq_o;
   endproperty
   a_irq_pin: assert property (p_irq_pin)
      else $error("irq level");

   property p_sda_pin;
      sda_oe |-> !sda_o;
   endproperty
   a_sda_pin: assert property (p_sda_pin)
      else $error("sda level");

   property p_reset_quiet;
      $rose(reset_n) |-> !sda_oe && !irq_oe;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("rst");

   property p_irq_cause;
      $rose(irq_oe) |-> $past(result_valid);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("irq");

   property p_irq_clear;
      $fell(irq_oe) |-> idle_q < 5'h10;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("clr");

   property p_ack_low;
      $rose(sda_oe) |-> !scl_i && !$past(scl_i);
   endproperty
   a_ack_low: assert property (p_ack_low)
      else $error("sda rise");

   property p_idle_release;
      scl_i && idle_q >= 5'h10 |-> !sda_oe;
   endproperty
   a_idle_release: assert property (p_idle_release)
      else $error("idle");

   property p_hold_high;
      scl_i && $past(scl_i) && $past(scl_i, 2) && $stable(sda_i) &&
      ($past(sda_i, 2) == sda_i) |-> $stable(sda_oe);
   endproperty
   a_hold_high: assert property (p_hold_high)
      else $error("hold");

   c_irq_set: cover property ($rose(irq_oe));
   c_irq_clr: cover property ($fell(irq_oe));
   c_ack: cover property ($rose(sda_oe) ##[1:20] $fell(sda_oe));
endmodule

bind prs_readout prs_checker prs_checker_inst (
   .clk(clk), .reset_n(reset_n), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .irq_o(irq_o), .irq_oe(irq_oe),
   .result_valid(result_valid), .result(result));

// ### verification/prs_host_model.sv
// i2c bus controller standing in for the host processor
// assumes pull-ups on both lines; four clk with scl high, five clk with scl low
`timescale 1ns/1ps

module prs_host_model (
   // clock
   input  wire logic clk,
   // device side of the data line
   input  wire logic sda_o,
   input  wire logic sda_oe,
   // resolved wire levels
   output logic      scl_w,
   output logic      sda_w
);
   logic scl_m = 1'b1;
   logic sda_m = 1'b1;

   // ==========================================================
   // wired-and with a pull-up: released means high
   assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
   assign scl_w = scl_m;

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      wt(4);
      scl_m = 1'b1;
      wt(4);
      r = sda_w;
      scl_m = 1'b0;
      wt(1);
   endtask

   // also serves repeated start: data rises while scl is low
   task automatic start();
      sda_m = 1'b1;
      wt(4);
      scl_m = 1'b1;
      wt(4);
      sda_m = 1'b0;
      wt(4);
      scl_m = 1'b0;
      wt(1);
   endtask

   task automatic stop();
      sda_m = 1'b0;
      wt(4);
      scl_m = 1'b1;
      wt(4);
      sda_m = 1'b1;
      wt(4);
   endtask

   task automatic byte_io(input logic [7:0] tx, input logic ai,
                          output logic [7:0] rx, output logic ao);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ai, ao);
   endtask

   // nak is high if any byte went unacknowledged
   task automatic wr(input logic [6:0] a, input logic [7:0] cmd,
                     input logic [7:0] d, input logic wd, output logic nak);
      logic [7:0] rx;
      logic       k;
      start();
      byte_io({a, 1'b0}, 1'b1, rx, nak);
      byte_io(cmd, 1'b1, rx, k);
      nak = nak | k;
      if (wd) begin
         byte_io(d, 1'b1, rx, k);
         nak = nak | k;
      end
      stop();
   endtask

   // low byte first; the first byte is acked only when a second follows
   task automatic rd(input logic [6:0] a, input logic two,
                     output logic [15:0] v);
      logic k;
      start();
      byte_io({a, 1'b1}, 1'b1, v[7:0], k);
      byte_io(8'hff, ~two, v[7:0], k);
      v[15:8] = 8'h00;
      if (two) begin
         byte_io(8'hff, 1'b1, v[15:8], k);
      end
      stop();
   endtask
endmodule

// ### verification/tb.sv
// self-checking bench for the proximity result readout
// assumes the host model on the i2c wires and the checker bound in
`timescale 1ns/1ps

module tb;
   localparam logic [6:0] SA = 7'h2a;
   // arbitrary identification value
   localparam logic [7:0] PC = 8'h5a;
   logic        clk;
   logic        reset_n;
   logic        scl;
   logic        sda;
   logic        sda_o;
   logic        sda_oe;
   logic        irq_o;
   logic        irq_oe;
   logic        rv;
   logic [15:0] res;
   logic [15:0] v;
   logic        k;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;

   prs_readout #(.SLAVE_ADDR(SA), .PART_CODE(PC)) prs_readout_inst (
      .clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .irq_o(irq_o), .irq_oe(irq_oe),
      .result_valid(rv), .result(res));
   prs_host_model prs_host_model_inst (.clk(clk), .sda_o(sda_o),
      .sda_oe(sda_oe), .scl_w(scl), .sda_w(sda));

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic rd_reg(input logic [4:0] a, input logic two);
      prs_host_model_inst.wr(SA, {1'b1, prs_pkg::TYPE_AUTOINC, a},
                             8'h00, 1'b0, k);
      prs_host_model_inst.rd(SA, two, v);
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      prs_host_model_inst.wr(SA, {1'b1, prs_pkg::TYPE_REPEAT, a}, d,
                             1'b1, k);
      chk(16'(k), 16'h0000);
   endtask

   task automatic conv(input logic [15:0] r);
      rv = 1'b1;
      res = r;
      @(negedge clk);
      rv = 1'b0;
      res = ~r;
      repeat (3) @(negedge clk);
   endtask

   task automatic clr();
      prs_host_model_inst.wr(SA, {1'b1, prs_pkg::TYPE_SPECIAL,
                             prs_pkg::SF_IRQ_CLEAR}, 8'h00, 1'b0, k);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_ident();
      chk({14'h0000, sda_oe, irq_oe}, 16'h0000);
      rd_reg(prs_pkg::ADDR_STATUS, 1'b0);
      chk(v, 16'h0000);
      wr_reg(prs_pkg::ADDR_PART_ID, 8'ha5);
      wr_reg(prs_pkg::ADDR_STATUS, 8'hff);
      rd_reg(prs_pkg::ADDR_PART_ID, 1'b1);
      chk(v, {8'h00, PC});
      prs_host_model_inst.wr(SA ^ 7'h01, 8'h80, 8'h00, 1'b0, k);
      chk(16'(k), 16'h0001);
      $display("test ident done");
   endtask

   task automatic t_count();
      conv(16'h1234);
      rd_reg(prs_pkg::ADDR_COUNT_LO, 1'b1);
      chk(v, 16'h1234);
      rd_reg(prs_pkg::ADDR_COUNT_LO, 1'b0);
      chk(v, 16'h0034);
      conv(16'habcd);
      prs_host_model_inst.rd(SA, 1'b0, v);
      chk(v, 16'h0012);
      prs_host_model_inst.wr(SA, {1'b1, prs_pkg::TYPE_REPEAT,
                             prs_pkg::ADDR_COUNT_LO}, 8'h00, 1'b0, k);
      prs_host_model_inst.rd(SA, 1'b1, v);
      chk(v, 16'hcdcd);
      rd_reg(prs_pkg::ADDR_COUNT_HI, 1'b0);
      chk(v, 16'h00ab);
      $display("test count done");
   endtask

   task automatic t_irq();
      wr_reg(prs_pkg::ADDR_THR_LO_H, 8'h01);
      wr_reg(prs_pkg::ADDR_THR_HI_H, 8'h02);
      wr_reg(prs_pkg::ADDR_ENABLE, 8'h20);
      conv(16'h0100);
      conv(16'h0200);
      chk(16'(irq_oe), 16'h0000);
      conv(16'h00ff);
      chk(16'(irq_oe), 16'h0001);
      rd_reg(prs_pkg::ADDR_STATUS, 1'b0);
      chk(v, 16'h0020);
      clr();
      chk(16'(irq_oe), 16'h0000);
      conv(16'h0201);
      chk(16'(irq_oe), 16'h0001);
      clr();
      wr_reg(prs_pkg::ADDR_ENABLE, 8'h00);
      conv(16'h0300);
      chk(16'(irq_oe), 16'h0000);
      $display("test irq done");
   endtask

   // ==========================================================
   // clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // whole run needs about 5300 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         $display("Error at %0t: timeout", $time);
         final_report();
      end
   end

   initial begin
      reset_n = 1'b0;
      rv = 1'b0;
      res = 16'h0000;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (2) @(negedge clk);
      t_ident();
      t_count();
      t_irq();
      final_report();
   end
endmodule
